// ---- hdl/rgc_top.sv ----
// Reset generation cascade: source OR tree, stretchers, monitor and guarded software requests
module rgc_top
    import rgc_pkg::*;
#(
    parameter logic [rgc_pkg::CNT_W-1:0] STRETCH = rgc_pkg::STRETCH_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ext_reset_n,
    input wire logic wdog_timeout,
    input wire logic sw_key_valid,
    input wire logic [rgc_pkg::KEY_W-1:0] sw_key,
    input wire logic sw_req_valid,
    input wire logic [rgc_pkg::NUM_OUT-1:0] sw_req,
    input wire logic [rgc_pkg::NUM_CAUSE-1:0] cause_clr,
    output logic [rgc_pkg::NUM_OUT-1:0] rst_out_n,
    output logic [rgc_pkg::NUM_CAUSE-1:0] cause_flags,
    output logic sw_unlocked
);

    import rgc_pkg::*;

    // Parent level in the cascade; memory-side resets hang off cold, the rest off warm
    function automatic int unsigned parent_of(input int unsigned idx);
        case (idx)
            int'(RGC_UNIT): parent_of = int'(RGC_POR);
            int'(RGC_CLKDOM): parent_of = int'(RGC_UNIT);
            int'(RGC_COLD): parent_of = int'(RGC_CLKDOM);
            int'(RGC_WARM): parent_of = int'(RGC_COLD);
            int'(RGC_SYSCTRL): parent_of = int'(RGC_COLD);
            int'(RGC_CFGID): parent_of = int'(RGC_COLD);
            int'(RGC_ESRAM): parent_of = int'(RGC_COLD);
            int'(RGC_SMEM): parent_of = int'(RGC_COLD);
            default: parent_of = int'(RGC_WARM);
        endcase
    endfunction : parent_of

    logic pin_s1_q;
    logic pin_s2_q;
    logic unlocked_q;
    logic [NUM_OUT-1:0] sw_hold_q;
    logic [NUM_CAUSE-1:0] cause_q;
    logic [NUM_OUT-1:0] src_w;
    logic [NUM_OUT-1:0] out_n_w;

    // Pull-up lives in the pad; an undriven pin arrives here high
    wire pin_act = ~pin_s2_q;
    wire unit_rst_n = out_n_w[RGC_UNIT];
    wire key_ok = sw_key_valid && (sw_key == UNLOCK_KEY);
    wire req_take = sw_req_valid && unlocked_q;
    // Power-on output may not be asked for by software
    wire [NUM_OUT-1:0] req_bits = sw_req & ~(28'h0000001);

    // Pin passes two flops; its own release is stretched further downstream
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end
        else
        begin
            pin_s1_q <= ext_reset_n;
            pin_s2_q <= pin_s1_q;
        end
    end

    // Key opens one request, then protection re-arms
    always_ff @(posedge sys_clk or negedge unit_rst_n)
    begin
        if (!unit_rst_n)
        begin
            unlocked_q <= 1'b0;
            sw_hold_q <= '0;
        end
        else
        begin
            if (req_take)
            begin
                unlocked_q <= 1'b0;
            end
            else if (key_ok)
            begin
                unlocked_q <= 1'b1;
            end
            sw_hold_q <= req_take ? req_bits : '0;
        end
    end

    // Source OR per output; cascade uses the parent's stretched state
    always_comb
    begin
        src_w = '0;
        src_w[RGC_POR] = 1'b0;
        for (int unsigned i = 1; i < NUM_OUT; i++)
        begin
            src_w[i] = ~out_n_w[parent_of(i)] | sw_hold_q[i];
        end
        src_w[RGC_UNIT] = src_w[RGC_UNIT] | pin_act;
        src_w[RGC_CLKDOM] = src_w[RGC_CLKDOM] | wdog_timeout;
    end

    // Each subsystem has its own stretcher, so those below cold and warm (outputs 5 to 27) can be reset alone
    for (genvar g = 0; g < NUM_OUT; g++)
    begin : g_chan
        rgc_rst_if rif ();
        assign rif.src_act = src_w[g];
        assign out_n_w[g] = rif.rst_act_n;
        // Runs on the always-on oscillator clock, never gated
        rgc_stretch #(.STRETCH(STRETCH)) u_stretch (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .rif(rif)
        );
    end

    // Monitor survives every reset but power-on; a new event beats a clear
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cause_q <= CAUSE_RESET;
        end
        else
        begin
            cause_q[CAUSE_POR] <= cause_q[CAUSE_POR] & ~cause_clr[CAUSE_POR];
            cause_q[CAUSE_PIN] <= pin_act | (cause_q[CAUSE_PIN] & ~cause_clr[CAUSE_PIN]);
            cause_q[CAUSE_WDOG] <= wdog_timeout | (cause_q[CAUSE_WDOG] & ~cause_clr[CAUSE_WDOG]);
            cause_q[CAUSE_SW] <= req_take | (cause_q[CAUSE_SW] & ~cause_clr[CAUSE_SW]);
        end
    end

    // Warm sources CAN and CPU/bus like the rest, cold-only domains untouched
    // Cold drives its own memory-side group
    assign rst_out_n = out_n_w;
    assign cause_flags = cause_q;
    assign sw_unlocked = unlocked_q;

endmodule : rgc_top

// ---- hdl/rgc_pkg.sv ----
// Constants and types shared by the reset generation cascade
package rgc_pkg;

    localparam int unsigned NUM_OUT = 28;
    localparam int unsigned NUM_CAUSE = 4;
    localparam int unsigned CNT_W = 8;
    localparam logic [CNT_W-1:0] STRETCH_CYCLES = 8'h10;
    localparam int unsigned KEY_W = 16;
    // Unlock key value is arbitrary
    localparam logic [KEY_W-1:0] UNLOCK_KEY = 16'hA5C3;

    // Reset values of the source-monitor flags: power-on is the first cause
    localparam logic [NUM_CAUSE-1:0] CAUSE_RESET = 4'h1;
    localparam int unsigned CAUSE_POR = 0;
    localparam int unsigned CAUSE_PIN = 1;
    localparam int unsigned CAUSE_WDOG = 2;
    localparam int unsigned CAUSE_SW = 3;

    typedef enum logic [4:0] {
        RGC_POR = 5'h00,
        RGC_UNIT = 5'h01,
        RGC_CLKDOM = 5'h02,
        RGC_COLD = 5'h03,
        RGC_WARM = 5'h04,
        RGC_SYSCTRL = 5'h05,
        RGC_CFGID = 5'h06,
        RGC_ESRAM = 5'h07,
        RGC_SMEM = 5'h08,
        RGC_GEN_BRIDGE = 5'h09,
        RGC_PERIPH_BRIDGE = 5'h0A,
        RGC_GPIO = 5'h0B,
        RGC_UART = 5'h0C,
        RGC_PTIMER = 5'h0D,
        RGC_SPI = 5'h0E,
        RGC_VNET_BRIDGE = 5'h0F,
        RGC_CAN = 5'h10,
        RGC_LIN = 5'h11,
        RGC_MS_BRIDGE = 5'h12,
        RGC_PWM = 5'h13,
        RGC_ADC = 5'h14,
        RGC_MS_TIMER = 5'h15,
        RGC_I2C = 5'h16,
        RGC_ENCODER = 5'h17,
        RGC_DMA = 5'h18,
        RGC_USB = 5'h19,
        RGC_INTCTRL = 5'h1A,
        RGC_CPU_BUS = 5'h1B
    } rgc_out_t;

endpackage : rgc_pkg

// ---- hdl/rgc_rst_if.sv ----
// Source and stretched-reset pair between the cascade and one stretcher
interface rgc_rst_if;
    logic src_act;
    logic rst_act_n;
    modport unit (output src_act, input rst_act_n);
    modport stretcher (input src_act, output rst_act_n);
endinterface : rgc_rst_if

// ---- hdl/rgc_stretch.sv ----
// One reset channel: asynchronous assertion, synchronised and stretched release
module rgc_stretch
    import rgc_pkg::*;
#(
    parameter logic [rgc_pkg::CNT_W-1:0] STRETCH = rgc_pkg::STRETCH_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    rgc_rst_if.stretcher rif
);

    logic s1_q;
    logic s2_q;
    logic [CNT_W-1:0] cnt_q;
    logic out_n_q;
    wire arst_n = rst_n & ~rif.src_act;
    wire done = (cnt_q == STRETCH - 8'h01);

    // Source drops straight into the async clear, so assertion needs no clock
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end
        else
        begin
            s1_q <= 1'b1;
            s2_q <= s1_q;
        end
    end

    // Release only after the synchronised removal plus the stretch count
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= '0;
            out_n_q <= 1'b0;
        end
        else
        begin
            if (s2_q && !done)
            begin
                cnt_q <= cnt_q + 8'h01;
            end
            out_n_q <= s2_q && done;
        end
    end

    assign rif.rst_act_n = out_n_q;

endmodule : rgc_stretch

// ---- dv/rgc_checker.sv ----
// Port-level assertions for the reset generation cascade
module rgc_checker
    import rgc_pkg::*;
#(
    parameter logic [rgc_pkg::CNT_W-1:0] STRETCH = rgc_pkg::STRETCH_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ext_reset_n,
    input wire logic wdog_timeout,
    input wire logic sw_key_valid,
    input wire logic [rgc_pkg::KEY_W-1:0] sw_key,
    input wire logic sw_req_valid,
    input wire logic [rgc_pkg::NUM_OUT-1:0] sw_req,
    input wire logic [rgc_pkg::NUM_CAUSE-1:0] cause_clr,
    input wire logic [rgc_pkg::NUM_OUT-1:0] rst_out_n,
    input wire logic [rgc_pkg::NUM_CAUSE-1:0] cause_flags,
    input wire logic sw_unlocked
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // Pin passes two sync flops, so three low samples must reach the unit reset
    sequence pin_held; !ext_reset_n [*3]; endsequence
    sequence key_ok; sw_key_valid && !sw_req_valid && sw_key == UNLOCK_KEY && rst_out_n[1]; endsequence
    unit_from_pin_a: assert property (pin_held |-> !rst_out_n[1])
        else $error("pin did not reset unit");
    unit_from_por_a: assert property (!rst_out_n[0] |-> !rst_out_n[1])
        else $error("unit free during power-on");
    clkdom_src_a: assert property (!rst_out_n[1] || wdog_timeout |-> !rst_out_n[2])
        else $error("clock-domain reset missed source");
    cold_warm_a: assert property (!rst_out_n[2] |-> rst_out_n[4:3] == 2'h0)
        else $error("cold or warm missed parent");
    cold_kids_a: assert property (!rst_out_n[3] |-> rst_out_n[8:5] == 4'h0)
        else $error("cold children missed");
    warm_kids_a: assert property (!rst_out_n[4] |-> rst_out_n[27:9] == 19'h0)
        else $error("warm children missed");
    stretch_rel_a: assert property ($rose(rst_out_n[2]) |-> !$past(wdog_timeout, 3) && $past(rst_out_n[1], 3))
        else $error("release not stretched");
    key_unlock_a: assert property (key_ok |=> sw_unlocked)
        else $error("key not accepted");
    req_take_a: assert property (sw_unlocked && sw_req_valid && |sw_req[27:1] |=> !sw_unlocked && cause_flags[3])
        else $error("request not taken");
    wdog_cause_a: assert property (wdog_timeout |=> cause_flags[2])
        else $error("watchdog cause lost");
endmodule : rgc_checker

bind rgc_top rgc_checker #(.STRETCH(STRETCH)) u_chk (.sys_clk, .rst_n, .ext_reset_n, .wdog_timeout, .sw_key_valid,
    .sw_key, .sw_req_valid, .sw_req, .cause_clr, .rst_out_n, .cause_flags, .sw_unlocked);

// ---- dv/rgc_pin_model.sv ----
// Board reset pin: driven low on request, pulled up otherwise
module rgc_pin_model
(
    input wire logic press,
    output logic ext_reset_n
);
    timeunit 1ns;
    timeprecision 1ps;
    assign ext_reset_n = press ? 1'h0 : 1'h1;
endmodule : rgc_pin_model

// ---- dv/rgc_top_tb.sv ----
// Self-checking bench for the reset generation cascade
module rgc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rgc_pkg::*;
    // Short stretch keeps each release walk under forty cycles
    localparam logic [CNT_W-1:0] STR = 8'h04;
    logic sys_clk = 1'h0, rst_n = 1'h0, press = 1'h0, wdog_timeout = 1'h0, sw_key_valid = 1'h0, sw_req_valid = 1'h0;
    logic ext_reset_n, sw_unlocked;
    logic [KEY_W-1:0] sw_key = 16'h0000;
    logic [NUM_OUT-1:0] sw_req = 28'h0, rst_out_n;
    logic [NUM_CAUSE-1:0] cause_clr = 4'h0, cause_flags;
    int failures = 0, total_checks = 0;
    rgc_pin_model u_pin (.press, .ext_reset_n);
    rgc_top #(.STRETCH(STR)) DUT (.sys_clk, .rst_n, .ext_reset_n, .wdog_timeout, .sw_key_valid, .sw_key,
        .sw_req_valid, .sw_req, .cause_clr, .rst_out_n, .cause_flags, .sw_unlocked);
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [27:0] got, input logic [27:0] exp, input string msg);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    task automatic wait_rel();
        int i = 0;
        while (rst_out_n !== 28'hFFFFFFF && i < 500)
        begin
            step(1);
            i++;
        end
        if (i == 500)
        begin
            failures++;
            stop_test();
        end
    endtask : wait_rel
    task automatic clr(input logic [3:0] b);
        cause_clr = b;
        step(1);
        cause_clr = 4'h0;
        chk({24'h0, cause_flags & b}, 28'h0, "flag not cleared");
    endtask : clr
    task automatic key(input logic [15:0] k);
        sw_key = k;
        sw_key_valid = 1'h1;
        step(1);
        sw_key_valid = 1'h0;
    endtask : key
    // Outputs pulled low by a request on output i, itself plus its descendants
    function automatic logic [27:0] exp_low(input int i);
        logic [27:0] m = 28'h0;
        for (int k = 1; k < 28; k++)
            if (k == i || (i < 4 && k > i) || (i == 4 && k > 8))
                m[k] = 1'h1;
        return m;
    endfunction : exp_low
    task automatic t_wdog();
        wdog_timeout = 1'h1;
        step(1);
        wdog_timeout = 1'h0;
        chk(rst_out_n, 28'h3, "watchdog cascade");
        chk({24'h0, cause_flags}, 28'h4, "watchdog cause");
        step(2);
        chk({27'h0, rst_out_n[2]}, 28'h0, "released early");
        wait_rel();
        clr(4'h4);
        $display("watchdog test done");
    endtask : t_wdog
    task automatic t_pin();
        key(UNLOCK_KEY);
        chk({27'h0, sw_unlocked}, 28'h1, "not unlocked");
        press = 1'h1;
        step(4);
        press = 1'h0;
        chk(rst_out_n, 28'h1, "pin cascade");
        chk({26'h0, cause_flags[1], sw_unlocked}, 28'h2, "pin cause or lock");
        wait_rel();
        clr(4'h2);
        $display("pin test done");
    endtask : t_pin
    task automatic t_sw();
        key(~UNLOCK_KEY);
        sw_req = 28'h10;
        sw_req_valid = 1'h1;
        step(1);
        sw_req_valid = 1'h0;
        step(2);
        chk(rst_out_n, 28'hFFFFFFF, "locked request taken");
        key(UNLOCK_KEY);
        sw_req = 28'h1;
        sw_req_valid = 1'h1;
        step(1);
        sw_req_valid = 1'h0;
        step(2);
        chk(rst_out_n, 28'hFFFFFFF, "power-on request taken");
        chk({27'h0, sw_unlocked}, 28'h0, "unlock not consumed");
        clr(4'h8);
        for (int i = 1; i < 28; i++)
        begin
            key(UNLOCK_KEY);
            sw_req = 28'h1 << i;
            sw_req_valid = 1'h1;
            step(1);
            sw_req_valid = 1'h0;
            step(1);
            chk(rst_out_n, ~exp_low(i), "software reset");
            chk({27'h0, cause_flags[3]}, 28'h1, "software cause");
            wait_rel();
            clr(4'h8);
        end
        $display("software test done");
    endtask : t_sw
    initial
    begin
        step(10);
        chk(rst_out_n, 28'h0, "outputs free in reset");
        rst_n = 1'h1;
        wait_rel();
        chk({23'h0, sw_unlocked, cause_flags}, {24'h0, CAUSE_RESET}, "reset state");
        clr(4'h1);
        $display("power-on test done");
        t_wdog();
        t_pin();
        t_sw();
        stop_test();
    end
endmodule : rgc_top_tb
